// File: src/flash_lock_cmd_regs.vh
// Opcodes, register map, field positions and timing counts of the flash command block
`ifndef FLASH_LOCK_CMD_REGS_VH
`define FLASH_LOCK_CMD_REGS_VH

`define CLK_PERIOD_NS 10
`define HW_CLEAR_PULSE_MIN_NS 1000
`define HW_CLEAR_PULSE_CYCLES ((`HW_CLEAR_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_RECOVERY_TIME_NS 30000
`define CLEAR_RECOVERY_CYCLES (`CLEAR_RECOVERY_TIME_NS / `CLK_PERIOD_NS)
`define CLEAR_RECOVERY_STATUS_WR_NS 12000000

`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hd8
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_UNIT_LOCK 8'h36
`define OP_UNIT_UNLOCK 8'h39
`define OP_UNIT_LOCK_QUERY 8'h3d
`define OP_ALL_LOCK 8'h7e
`define OP_ALL_UNLOCK 8'h98
`define OP_CLEAR_ARM 8'h66
`define OP_CLEAR_FIRE 8'h99
`define OP_NULL 8'h00

`define REG_CONFIG 12'h000
`define REG_STATUS 12'h004
`define REG_FAULT_CLR 12'h008

`define CFG_LOCK_SCHEME 0
`define CFG_QUAD_MODE 1
`define CFG_RANGE_INVERT 2
`define CFG_RANGE_LO 3
`define CFG_RANGE_HI 7
`define CFG_RESET 8'h00

`define ST_IN_PROGRESS 0
`define ST_WRITE_LATCH 1
`define ST_FAULT 2
`define ST_ARMED 3
`define ST_PAUSED 15

`endif

// File: src/flash_lock_cmd.v
// Serial flash command logic: suspend/resume, unit locks and resets, APB view
//
// Design decisions made here: register access over APB and the register addresses.
`include "flash_lock_cmd_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module flash_lock_cmd #(
  parameter PROG_CYCLES = 200,
  parameter ERASE_CYCLES = 2000
) (
  input wire pclk, // APB clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire cs_n, // Link chip select, active low
  input wire sclk, // Link serial clock
  input wire [3:0] sio_in, // Link data lines in
  output reg [3:0] sio_out, // Link data lines out
  output reg [3:0] sio_oe, // Link data line enables
  input wire hw_reset_n // Reset pin, active low
);

  localparam K_PROG = 2'd0;
  localparam K_SECT = 2'd1;
  localparam K_BLK = 2'd2;
  // Recovery count is trimmed to the width of its counter on load
  localparam integer REC_CYCLES = `CLEAR_RECOVERY_CYCLES;

  reg cs_s1, cs_s2, cs_prev, ck_s1, ck_s2, ck_prev, rst_s1, rst_s2;
  reg [3:0] io_s1, io_s2;
  reg [31:0] sr;
  reg [5:0] bits;
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [7:0] out_byte;
  reg [7:0] cfg;
  reg [255:0] lock;
  reg write_latch_bit, fault, armed;
  reg er_act, er_pause, pg_act, pg_pause, pg_nested;
  reg [1:0] er_kind;
  reg [23:0] er_addr, pg_addr;
  reg [31:0] er_cnt, pg_cnt;
  reg [11:0] pulse_cnt;
  reg [15:0] rec_cnt;
  reg soft_clr;
  integer i;

  wire quad = cfg[`CFG_QUAD_MODE];
  wire ck_rise = ck_s2 & ~ck_prev;
  wire ck_fall = ~ck_s2 & ck_prev;
  wire cs_rise = cs_s2 & ~cs_prev;
  wire [5:0] step = quad ? 6'd4 : 6'd1;
  wire [5:0] next_bits = (bits > 6'd44) ? bits : bits + step;
  wire [31:0] next_sr = quad ? {sr[27:0], io_s2} : {sr[30:0], io_s2[0]};
  wire hw_held = ~rst_s2 && (pulse_cnt >= `HW_CLEAR_PULSE_CYCLES);
  wire clr = soft_clr | hw_held;
  wire in_progress = (er_act & ~er_pause) | (pg_act & ~pg_pause);
  wire paused_flag = er_pause | pg_pause;
  wire on_byte = (bits[2:0] == 3'd0);

  // Block is in the top-area range selected by the range bits, optionally inverted
  function range_hit;
    input [3:0] blk;
    input [4:0] bp;
    input inv;
    reg hit;
    begin
      if (bp == 5'd0)
        hit = 1'b0;
      else if (bp >= 5'd5)
        hit = 1'b1;
      else
        hit = ({1'b0, blk} >= (5'd16 - (5'd1 << (bp - 5'd1))));
      range_hit = hit ^ inv;
    end
  endfunction

  // Any lock bit set within the target unit
  function unit_locked;
    input [255:0] lk;
    input [23:0] a;
    input whole_blk;
    integer j;
    begin
      unit_locked = lk[a[19:12]];
      if (whole_blk) begin
        for (j = 0; j < 16; j = j + 1)
          unit_locked = unit_locked | lk[{a[19:16], j[3:0]}];
      end
    end
  endfunction

  // Lock units are 4 KB sectors in the outer blocks, 64 KB blocks elsewhere
  function small_unit;
    input [23:0] a;
    begin
      small_unit = (a[19:16] == 4'h0) || (a[19:16] == 4'hf);
    end
  endfunction

  function is_protected;
    input [255:0] lk;
    input [7:0] c;
    input [23:0] a;
    input whole_blk;
    begin
      if (c[`CFG_LOCK_SCHEME])
        is_protected = unit_locked(lk, a, whole_blk);
      else
        is_protected = range_hit(a[19:16], c[`CFG_RANGE_HI:`CFG_RANGE_LO],
          c[`CFG_RANGE_INVERT]);
    end
  endfunction

  // Program target inside the unit of the paused erase
  wire erase_clash = er_pause && ((er_kind == K_BLK) ? (addr[19:16] == er_addr[19:16]) :
    (addr[19:12] == er_addr[19:12]));

  // Link pins and reset pin cross into pclk through two flops each
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_prev <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_prev <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_prev <= cs_s2;
      ck_s1 <= sclk;
      ck_s2 <= ck_s1;
      ck_prev <= ck_s2;
      io_s1 <= sio_in;
      io_s2 <= io_s1;
      rst_s1 <= hw_reset_n;
      rst_s2 <= rst_s1;
    end
  end

  // Reset pin pulse width and recovery window
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= 12'h000;
      rec_cnt <= 16'h0000;
    end else begin
      if (rst_s2)
        pulse_cnt <= 12'h000;
      else if (pulse_cnt < `HW_CLEAR_PULSE_CYCLES)
        pulse_cnt <= pulse_cnt + 12'h001;
      if (clr)
        rec_cnt <= REC_CYCLES[15:0];
      else if (rec_cnt != 16'h0000)
        rec_cnt <= rec_cnt - 16'h0001;
    end
  end

  // Serial shifter and lock query output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr <= 32'h0000_0000;
      bits <= 6'd0;
      opcode <= 8'h00;
      addr <= 24'h00_0000;
      out_byte <= 8'h00;
      sio_out <= 4'h0;
      sio_oe <= 4'h0;
    end else if (cs_s2 || clr || !rst_s2) begin
      // Float as soon as the pin is seen low, before the pulse qualifies
      bits <= 6'd0;
      sio_oe <= 4'h0;
    end else begin
      if (ck_rise) begin
        sr <= next_sr;
        bits <= next_bits;
        if (bits < 6'd8 && next_bits >= 6'd8)
          opcode <= next_sr[7:0];
        if (bits < 6'd32 && next_bits >= 6'd32) begin
          addr <= next_sr[23:0];
          out_byte <= {7'b000_0000, lock[next_sr[19:12]]};
        end
      end
      if (ck_fall && opcode == `OP_UNIT_LOCK_QUERY && bits >= 6'd32) begin
        if (quad) begin
          sio_out <= out_byte[7:4];
          sio_oe <= 4'hf;
          out_byte <= {out_byte[3:0], out_byte[7:4]};
        end else begin
          sio_out <= {2'b00, out_byte[7], 1'b0};
          sio_oe <= 4'h2;
          out_byte <= {out_byte[6:0], out_byte[7]};
        end
      end
    end
  end

  // Command execution at chip select release, plus the array operation timers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `CFG_RESET;
      lock <= {256{1'b1}};
      write_latch_bit <= 1'b0;
      fault <= 1'b0;
      armed <= 1'b0;
      er_act <= 1'b0;
      er_pause <= 1'b0;
      er_kind <= K_SECT;
      er_addr <= 24'h00_0000;
      er_cnt <= 32'h0000_0000;
      pg_act <= 1'b0;
      pg_pause <= 1'b0;
      pg_nested <= 1'b0;
      pg_addr <= 24'h00_0000;
      pg_cnt <= 32'h0000_0000;
      soft_clr <= 1'b0;
    end else if (clr) begin
      cfg <= `CFG_RESET;
      lock <= {256{1'b1}};
      write_latch_bit <= 1'b0;
      armed <= 1'b0;
      er_act <= 1'b0;
      er_pause <= 1'b0;
      pg_act <= 1'b0;
      pg_pause <= 1'b0;
      pg_nested <= 1'b0;
      soft_clr <= 1'b0;
      if (hw_held)
        fault <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == `REG_CONFIG)
        cfg <= pwdata[7:0];
      if (psel && penable && pready && pwrite && paddr == `REG_FAULT_CLR && pwdata[0])
        fault <= 1'b0;
      // Timers; a finished operation drops busy and write latch together
      if (pg_act && !pg_pause) begin
        if (pg_cnt == 32'h0000_0000) begin
          pg_act <= 1'b0;
          pg_nested <= 1'b0;
          write_latch_bit <= 1'b0;
        end else
          pg_cnt <= pg_cnt - 32'h0000_0001;
      end else if (er_act && !er_pause) begin
        if (er_cnt == 32'h0000_0000) begin
          er_act <= 1'b0;
          write_latch_bit <= 1'b0;
        end else
          er_cnt <= er_cnt - 32'h0000_0001;
      end
      if (cs_rise && rec_cnt == 16'h0000 && bits >= 6'd8) begin
        armed <= (opcode == `OP_CLEAR_ARM);
        case (opcode)
          `OP_CLEAR_FIRE: begin
            if (armed && bits == 6'd8)
              soft_clr <= 1'b1;
          end
          `OP_WRITE_ENABLE: begin
            if (!in_progress)
              write_latch_bit <= 1'b1;
          end
          `OP_WRITE_DISABLE: begin
            if (!in_progress)
              write_latch_bit <= 1'b0;
          end
          `OP_PAGE_PROGRAM: begin
            // Only idle, or with an erase paused and no program pending
            if (write_latch_bit && bits >= 6'd40 && on_byte && !in_progress && !pg_act) begin
              if (is_protected(lock, cfg, addr, 1'b0) || erase_clash) begin
                fault <= 1'b1;
                write_latch_bit <= 1'b0;
              end else begin
                pg_act <= 1'b1;
                pg_nested <= er_pause;
                pg_addr <= addr;
                pg_cnt <= PROG_CYCLES;
              end
            end
          end
          `OP_SECTOR_ERASE, `OP_BLOCK_ERASE: begin
            if (write_latch_bit && bits == 6'd32 && !in_progress && !er_act && !pg_act) begin
              if (is_protected(lock, cfg, addr, opcode == `OP_BLOCK_ERASE)) begin
                fault <= 1'b1;
                write_latch_bit <= 1'b0;
              end else begin
                er_act <= 1'b1;
                er_kind <= (opcode == `OP_BLOCK_ERASE) ? K_BLK : K_SECT;
                er_addr <= addr;
                er_cnt <= ERASE_CYCLES;
              end
            end
          end
          `OP_SUSPEND: begin
            if (pg_act && !pg_pause && !pg_nested) begin
              pg_pause <= 1'b1;
              write_latch_bit <= 1'b0;
            end else if (er_act && !er_pause && !pg_act) begin
              er_pause <= 1'b1;
              write_latch_bit <= 1'b0;
            end
          end
          `OP_RESUME: begin
            // A running nested program blocks the erase resume
            if (pg_pause) begin
              pg_pause <= 1'b0;
              write_latch_bit <= 1'b1;
            end else if (er_pause && !pg_act) begin
              er_pause <= 1'b0;
              write_latch_bit <= 1'b1;
            end
          end
          `OP_UNIT_LOCK, `OP_UNIT_UNLOCK: begin
            if (write_latch_bit && !in_progress && bits == 6'd32) begin
              write_latch_bit <= 1'b0;
              if (small_unit(addr))
                lock[addr[19:12]] <= (opcode == `OP_UNIT_LOCK);
              else begin
                for (i = 0; i < 16; i = i + 1)
                  lock[{addr[19:16], i[3:0]}] <= (opcode == `OP_UNIT_LOCK);
              end
            end
          end
          `OP_ALL_LOCK, `OP_ALL_UNLOCK: begin
            if (write_latch_bit && !in_progress && bits == 6'd8) begin
              write_latch_bit <= 1'b0;
              lock <= {256{opcode == `OP_ALL_LOCK}};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // APB slave: no wait states, answer registered from the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        pslverr <= ~(paddr == `REG_CONFIG || paddr == `REG_STATUS ||
          paddr == `REG_FAULT_CLR);
        prdata <= 32'h0000_0000;
        if (!pwrite && paddr == `REG_CONFIG)
          prdata <= {24'h00_0000, cfg};
        else if (!pwrite && paddr == `REG_STATUS) begin
          prdata[`ST_IN_PROGRESS] <= in_progress;
          prdata[`ST_WRITE_LATCH] <= write_latch_bit;
          prdata[`ST_FAULT] <= fault;
          prdata[`ST_ARMED] <= armed;
          prdata[`ST_PAUSED] <= paused_flag;
        end
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // flash_lock_cmd

`default_nettype wire

// File: test/flash_lock_cmd_assertions.sv
// Port-level checker for the flash command block
`timescale 1ns/1ns
`default_nettype none
module flash_lock_cmd_checker (
  input wire pclk, // APB clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB address
  input wire [31:0] pwdata, // APB write data
  input wire [31:0] prdata, // APB read data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire cs_n, // Link select, active low
  input wire sclk, // Link clock
  input wire [3:0] sio_in, // Link data in
  input wire [3:0] sio_out, // Link data out
  input wire [3:0] sio_oe, // Link data enables
  input wire hw_reset_n // Reset pin, active low
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_unmapped: assert property (pready && !(paddr == 12'h000 || paddr == 12'h004 ||
      paddr == 12'h008) |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (pready && (paddr == 12'h000 || paddr == 12'h004 ||
      paddr == 12'h008) |-> !pslverr)
    else $error("error on mapped access");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("data on failed access");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_oe_reset_float: assert property (!hw_reset_n [*4] |-> sio_oe == 4'h0)
    else $error("output driven in pin reset");
  a_oe_legal_mode: assert property (sio_oe == 4'h0 || sio_oe == 4'h2 || sio_oe == 4'hf)
    else $error("bad output enable pattern");
endmodule // flash_lock_cmd_checker
bind flash_lock_cmd flash_lock_cmd_checker flash_lock_cmd_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
  .hw_reset_n(hw_reset_n)
);
`default_nettype wire

// File: test/flash_host_model.sv
// Host-side link model: sends frames and captures the answer byte
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  output logic cs_n, // Chip select, active low
  output logic sclk, // Link clock, idles low
  output logic [3:0] sio_in, // Data lines to the device
  input wire logic [3:0] sio_out // Data lines from the device
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio_in = 4'h5;
  end
  // Opcode then address, MSB first; clocks past n capture line 1
  task automatic frame(input logic [39:0] d, input int n, input int m, input bit q,
      output logic [7:0] rd);
    // Step off the system clock edge before touching the pins
    #1;
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < m; i++) begin
      if (i >= n) sio_in = ~sio_in;
      else if (q) sio_in = d[39 - 4 * i -: 4];
      else sio_in = {~sio_in[3:1], d[39 - i]};
      #62;
      if (i >= n) rd = {rd[6:0], sio_out[1]};
      sclk = 1'b1;
      #63;
      sclk = 1'b0;
    end
    #62;
    cs_n = 1'b1;
    // Released lines must not keep showing the last bit
    sio_in = ~sio_in;
    #200;
  endtask
endmodule // flash_host_model
`default_nettype wire

// File: test/flash_lock_cmd_bench.sv
// Self-checking bench: register view and link commands of the flash block
`include "flash_lock_cmd_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module flash_lock_cmd_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic hw_reset_n = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, cs_n, sclk;
  logic [3:0] sio_in, sio_out, sio_oe;
  logic [7:0] ops [4] = '{`OP_UNIT_LOCK, `OP_UNIT_UNLOCK, `OP_ALL_LOCK, `OP_ALL_UNLOCK};
  logic [7:0] seed = 8'h1a;
  logic [31:0] r;
  logic e;
  logic [7:0] q;
  logic [23:0] a;
  logic exp_lock;
  int errors = 0;
  int n_tests = 0;
  always #5 pclk = ~pclk;
  flash_lock_cmd #(.PROG_CYCLES(200), .ERASE_CYCLES(5000)) flash_lock_cmd_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
    .hw_reset_n(hw_reset_n)
  );
  flash_host_model flash_host_model_i (
    .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in), .sio_out(sio_out)
  );
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic lock_after(input logic cur, input logic [7:0] op);
    if (op == `OP_UNIT_LOCK || op == `OP_ALL_LOCK) return 1'b1;
    if (op == `OP_UNIT_UNLOCK || op == `OP_ALL_UNLOCK) return 1'b0;
    return cur;
  endfunction
  task automatic give_verdict();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    n_tests++;
    if (got !== x) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, x);
    end
  endtask
  // Request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, ad, 32'h0000_0000);
    chk(r & m, x);
  endtask
  task automatic cmd(input logic [7:0] op, input int bits, input logic qd);
    flash_host_model_i.frame({op, a, 8'h00}, qd ? bits / 4 : bits, qd ? bits / 4 : bits, qd, q);
  endtask
  task automatic qchk();
    flash_host_model_i.frame({`OP_UNIT_LOCK_QUERY, a, 8'h00}, 32, 40, 1'b0, q);
    chk({24'h00_0000, q}, {31'h0000_0000, exp_lock});
  endtask
  task automatic sreset();
    cmd(`OP_CLEAR_ARM, 8, 1'b0);
    cmd(`OP_CLEAR_FIRE, 8, 1'b0);
    repeat (3100) @(posedge pclk);
  endtask
  initial begin
    #900_000;
    $display("[ERR] %0t watchdog expired", $time);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3100) @(posedge pclk);
    seed = lfsr(seed);
    // Block-sized unit: upper nibble never 0 or F
    a = {5'h00, seed[2:0] | 3'h1, seed, 8'h00};
    rdc(`REG_CONFIG, 32'hffff_ffff, 32'h0000_0000);
    rdc(`REG_STATUS, 32'hffff_ffff, 32'h0000_0000);
    apb(1'b0, {seed, 4'h0} | 12'h100, 32'h0000_0000);
    chk({r[30:0], e}, 32'h0000_0001);
    apb(1'b1, `REG_STATUS, 32'hffff_ffff);
    rdc(`REG_STATUS, 32'hffff_ffff, 32'h0000_0000);
    exp_lock = 1'b1;
    qchk();
    cmd(`OP_UNIT_UNLOCK, 32, 1'b0);
    qchk();
    for (int k = 0; k < 8; k++) begin
      if (k[2]) apb(1'b1, `REG_CONFIG, 32'h0000_0002);
      cmd(`OP_WRITE_ENABLE, 8, k[2]);
      cmd(ops[k % 4], k[1] ? 8 : 32, k[2]);
      if (k[2]) apb(1'b1, `REG_CONFIG, 32'h0000_0000);
      exp_lock = lock_after(exp_lock, ops[k % 4]);
      qchk();
    end
    for (int j = 0; j < 2; j++) begin
      cmd(`OP_WRITE_ENABLE, 8, 1'b0);
      cmd(j ? `OP_ALL_LOCK : `OP_UNIT_LOCK, j ? 9 : 33, 1'b0);
      qchk();
    end
    cmd(`OP_CLEAR_ARM, 8, 1'b0);
    rdc(`REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    cmd(`OP_NULL, 8, 1'b0);
    rdc(`REG_STATUS, 32'h0000_0008, 32'h0000_0000);
    cmd(`OP_CLEAR_FIRE, 8, 1'b0);
    qchk();
    cmd(`OP_WRITE_ENABLE, 8, 1'b0);
    sreset();
    rdc(`REG_STATUS, 32'hffff_ffff, 32'h0000_0000);
    exp_lock = 1'b1;
    qchk();
    apb(1'b1, `REG_CONFIG, 32'h0000_0001);
    cmd(`OP_WRITE_ENABLE, 8, 1'b0);
    cmd(`OP_SECTOR_ERASE, 32, 1'b0);
    rdc(`REG_STATUS, 32'h0000_0007, 32'h0000_0004);
    sreset();
    rdc(`REG_STATUS, 32'h0000_0007, 32'h0000_0004);
    rdc(`REG_CONFIG, 32'hffff_ffff, 32'h0000_0000);
    apb(1'b1, `REG_FAULT_CLR, 32'h0000_0001);
    cmd(`OP_WRITE_ENABLE, 8, 1'b0);
    cmd(`OP_SECTOR_ERASE, 32, 1'b0);
    rdc(`REG_STATUS, 32'h0000_0005, 32'h0000_0001);
    cmd(`OP_SUSPEND, 8, 1'b0);
    rdc(`REG_STATUS, 32'h0000_8000, 32'h0000_8000);
    a = a ^ 24'h08_0000;
    cmd(`OP_WRITE_ENABLE, 8, 1'b0);
    cmd(`OP_PAGE_PROGRAM, 40, 1'b0);
    rdc(`REG_STATUS, 32'h0000_0007, 32'h0000_0003);
    cmd(`OP_SUSPEND, 8, 1'b0);
    rdc(`REG_STATUS, 32'h0000_0007, 32'h0000_0003);
    repeat (300) @(posedge pclk);
    rdc(`REG_STATUS, 32'h0000_0003, 32'h0000_0000);
    a = a ^ 24'h08_0000;
    cmd(`OP_WRITE_ENABLE, 8, 1'b0);
    cmd(`OP_PAGE_PROGRAM, 40, 1'b0);
    rdc(`REG_STATUS, 32'h0000_0007, 32'h0000_0004);
    cmd(`OP_RESUME, 8, 1'b0);
    rdc(`REG_STATUS, 32'h0000_8003, 32'h0000_0003);
    repeat (100) @(posedge pclk);
    cmd(`OP_SUSPEND, 8, 1'b0);
    rdc(`REG_STATUS, 32'h0000_8001, 32'h0000_8000);
    // Pin reset lands while the query answer is being driven
    fork
      flash_host_model_i.frame({`OP_UNIT_LOCK_QUERY, a, 8'h00}, 32, 40, 1'b0, q);
      begin
        repeat (420) @(posedge pclk);
        chk({28'h000_0000, sio_oe}, 32'h0000_0002);
        hw_reset_n <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({28'h000_0000, sio_oe}, 32'h0000_0000);
        repeat (140) @(posedge pclk);
        hw_reset_n <= 1'b1;
      end
    join
    repeat (3100) @(posedge pclk);
    rdc(`REG_STATUS, 32'hffff_ffff, 32'h0000_0000);
    qchk();
    give_verdict();
  end
endmodule // flash_lock_cmd_bench
`default_nettype wire
